// >>> rtl/sidrv_pkg.sv
// Package with constants for the serial-in latched low-side driver
package sidrv_pkg;
  localparam int          CHANNELS   = 8;
  localparam int          LAST_STAGE = 7;
  localparam logic [7:0]  SHIFT_RST  = 8'h00;
  localparam logic [7:0]  STORE_RST  = 8'h00;
  localparam logic [7:0]  ALL_OFF    = 8'h00;
endpackage : sidrv_pkg

// >>> rtl/serial_in_latched_low_side_driver.sv
// Logic core of an eight-channel serial-in latched low-side driver
`timescale 1ns/10ps

module serial_in_latched_low_side_driver
(
  input  wire logic       sys_clk,
  input  wire logic       rst_b,
  input  wire logic       clk_en,
  input  wire logic       shift_clock_in,
  input  wire logic       latch_clock_in,
  input  wire logic       shift_clear_n,
  input  wire logic       out_enable_n,
  input  wire logic       serial_in,
  output logic            serial_cascade_out,
  output logic [7:0]      switch_on,
  output logic [7:0]      switch_drain_o,
  output logic [7:0]      switch_drain_oe_n
);

  // Pin timing in sys_clk edges, counting the edge that first samples a pin change as edge 1:
  // edges 1 and 2 fill the synchroniser, edge 3 acts on the detected level or edge.
  // Pin pulses under one sys_clk period can be lost; this is the cost of
  // sampling every pin on one clock rather than clocking flops from the pins.
  // Serial data takes the same two-stage path, so it stays aligned with its edge.

  // All block state in one record, loaded by the single register process
  typedef struct packed {
    logic [1:0] sck_sync;
    logic [1:0] lck_sync;
    logic [1:0] clr_sync;
    logic [1:0] oen_sync;
    logic [1:0] din_sync;
    logic       sck_prev;
    logic       lck_prev;
    logic [7:0] shift;
    logic [7:0] store;
    logic [7:0] buf_on;
  } state_s;

  state_s st_r;
  state_s st_nxt;
  logic   sck_rise;
  logic   lck_rise;

  // Edges are found on second synchroniser stages only
  assign sck_rise = st_r.sck_sync[1] & ~st_r.sck_prev;
  assign lck_rise = st_r.lck_sync[1] & ~st_r.lck_prev;

  // Next-state logic for synchronisers, shift, storage and output buffers
  always_comb
  begin
    st_nxt          = st_r;
    // Synchronisers and edge history advance every enabled cycle
    st_nxt.sck_sync = {st_r.sck_sync[0], shift_clock_in};
    st_nxt.lck_sync = {st_r.lck_sync[0], latch_clock_in};
    st_nxt.clr_sync = {st_r.clr_sync[0], shift_clear_n};
    st_nxt.oen_sync = {st_r.oen_sync[0], out_enable_n};
    st_nxt.din_sync = {st_r.din_sync[0], serial_in};
    st_nxt.sck_prev = st_r.sck_sync[1];
    st_nxt.lck_prev = st_r.lck_sync[1];
    // Stage 0 takes the new bit, stage n takes stage n-1
    if (sck_rise)
    begin
      st_nxt.shift = {st_r.shift[6:0], st_r.din_sync[1]};
    end
    // Latch samples the old shift word, matching parallel flip-flops
    if (lck_rise)
    begin
      st_nxt.store = st_r.shift;
    end
    // Clear wins over a coincident shift edge; it is a level, not clocked
    if (!st_r.clr_sync[1])
    begin
      st_nxt.shift = sidrv_pkg::SHIFT_RST;
    end
    // Buffers are transparent to storage unless the enable is high
    // Registered copy adds no cycle: it loads together with the storage word
    if (st_r.oen_sync[1])
    begin
      st_nxt.buf_on = sidrv_pkg::ALL_OFF;
    end
    else
    begin
      st_nxt.buf_on = st_nxt.store;
    end
  end

  // State register; clock enable freezes everything
  always_ff @(posedge sys_clk)
  begin
    // Synchronisers start at the idle pin levels, so no false edge or enable follows reset
    if (!rst_b)
    begin
      st_r          <= '0;
      st_r.oen_sync <= 2'h3;
      st_r.clr_sync <= 2'h3;
      st_r.store    <= sidrv_pkg::STORE_RST;
      st_r.shift    <= sidrv_pkg::SHIFT_RST;
    end
    // Low clock enable holds every field; pins go unsampled meanwhile
    else if (clk_en)
    begin
      st_r <= st_nxt;
    end
  end

  // Open-drain pins: pulled low (enable low) only where the switch is on
  assign serial_cascade_out = st_r.shift[sidrv_pkg::LAST_STAGE];
  assign switch_on          = st_r.buf_on;
  assign switch_drain_o     = sidrv_pkg::ALL_OFF;
  assign switch_drain_oe_n  = ~st_r.buf_on;

  // Clear is a level: any cycle it is seen low leaves the shift stages empty
  AST_CLEAR_ZEROES: assert property (@(posedge sys_clk) disable iff (!rst_b)
    (clk_en && !st_r.clr_sync[1]) |=> (st_r.shift == 8'h00))
    else $error("shift register not cleared");

  // A detected shift edge moves every stage and takes the synchronised data bit
  AST_SHIFT_IN: assert property (@(posedge sys_clk) disable iff (!rst_b)
    (clk_en && sck_rise && st_r.clr_sync[1])
      |=> (st_r.shift == {$past(st_r.shift[6:0]), $past(st_r.din_sync[1])}))
    else $error("shift did not advance");

  // No edge, no movement
  AST_SHIFT_HOLD: assert property (@(posedge sys_clk) disable iff (!rst_b)
    (clk_en && !sck_rise && st_r.clr_sync[1]) |=> $stable(st_r.shift))
    else $error("shift changed without edge");

  // Storage takes the shift word as it stood before a coincident shift edge
  AST_LATCH: assert property (@(posedge sys_clk) disable iff (!rst_b)
    (clk_en && lck_rise) |=> (st_r.store == $past(st_r.shift)))
    else $error("storage did not latch");

  // Storage holds between latch edges
  AST_STORE_HOLD: assert property (@(posedge sys_clk) disable iff (!rst_b)
    (clk_en && !lck_rise) |=> $stable(st_r.store))
    else $error("storage changed without edge");

  // Enable high switches every load off one cycle after it is seen
  AST_OFF_WHEN_DISABLED: assert property (@(posedge sys_clk) disable iff (!rst_b)
    (clk_en && st_r.oen_sync[1]) |=> (switch_on == 8'h00 && switch_drain_oe_n == 8'hff))
    else $error("switch on while disabled");

  // Enable low: buffers mirror storage in the cycle it loads
  AST_TRANSPARENT: assert property (@(posedge sys_clk) disable iff (!rst_b)
    (clk_en && !st_r.oen_sync[1]) |=> (switch_on == st_r.store))
    else $error("buffers not following storage");

  // Cascade output moves with the shift, carrying stage 6 into stage 7
  AST_CASCADE: assert property (@(posedge sys_clk) disable iff (!rst_b)
    (clk_en && sck_rise && st_r.clr_sync[1])
      |=> (serial_cascade_out == $past(st_r.shift[6])))
    else $error("cascade output wrong");

  // Open-drain data stays low; only the enable moves, low where a switch sinks
  AST_DRAIN_MAP: assert property (@(posedge sys_clk) disable iff (!rst_b)
    (switch_drain_oe_n == ~switch_on) && (switch_drain_o == 8'h00))
    else $error("drain pin does not match buffer");

  // Frozen clock enable must leave every flop alone, synchronisers included
  AST_FREEZE: assert property (@(posedge sys_clk) disable iff (!rst_b)
    (!clk_en) |=> $stable(st_r))
    else $error("state moved while clock enable low");

  // Reset leaves every switch off and the cascade output low
  AST_RESET_OFF: assert property (@(posedge sys_clk)
    (!rst_b) |=> (switch_on == sidrv_pkg::ALL_OFF && serial_cascade_out == 1'h0
                  && st_r.store == sidrv_pkg::STORE_RST))
    else $error("outputs not off after reset");

  // Clock and data pass the same two stages, keeping them aligned
  AST_SYNC_DELAY: assert property (@(posedge sys_clk) disable iff (!rst_b)
    clk_en |=> (st_r.sck_sync[1] == $past(st_r.sck_sync[0]) &&
                st_r.din_sync[1] == $past(st_r.din_sync[0])))
    else $error("synchroniser stage skipped");

  // A latch edge with the enable low reaches the switches one cycle later
  AST_LATCH_TO_PINS: assert property (@(posedge sys_clk) disable iff (!rst_b)
    (clk_en && lck_rise && !st_r.oen_sync[1])
      |=> (switch_on == $past(st_r.shift)))
    else $error("latched word not at switches");

  // With clear high, the cascade output only moves on a shift edge
  AST_CASCADE_HOLD: assert property (@(posedge sys_clk) disable iff (!rst_b)
    (clk_en && !sck_rise && st_r.clr_sync[1]) |=> $stable(serial_cascade_out))
    else $error("cascade output changed without edge");

  // Clear also empties the last stage, so a chain sees zeros
  AST_CLEAR_CASCADE: assert property (@(posedge sys_clk) disable iff (!rst_b)
    (clk_en && !st_r.clr_sync[1]) |=> (serial_cascade_out == 1'h0))
    else $error("cascade output not cleared");

  // Clear touches only the shift stages; storage keeps feeding the buffers
  AST_CLEAR_KEEPS_STORE: assert property (@(posedge sys_clk) disable iff (!rst_b)
    (clk_en && !st_r.clr_sync[1] && !lck_rise) |=> $stable(st_r.store))
    else $error("clear disturbed storage");

  // Enable high gates the buffers only; storage is kept for later
  AST_DISABLE_KEEPS_STORE: assert property (@(posedge sys_clk) disable iff (!rst_b)
    (clk_en && st_r.oen_sync[1] && !lck_rise) |=> $stable(st_r.store))
    else $error("disable disturbed storage");

  // Per-channel view of the pins, so a failure names the channel
  for (genvar ch = 0; ch < sidrv_pkg::CHANNELS; ch++)
  begin : g_chan
    AST_CHAN_PULL: assert property (@(posedge sys_clk) disable iff (!rst_b)
      (!switch_drain_oe_n[ch]) |-> st_r.store[ch])
      else $error("channel pulled low without a stored one");

    AST_CHAN_FOLLOW: assert property (@(posedge sys_clk) disable iff (!rst_b)
      (clk_en && !st_r.oen_sync[1]) |=> (switch_on[ch] == st_r.store[ch]))
      else $error("channel buffer not following its storage bit");
  end : g_chan

endmodule : serial_in_latched_low_side_driver

// >>> verif/ctl_model.sv
// Controller model that shifts and latches data into the driver
`timescale 1ns/10ps
module ctl_model
(
  input  wire logic sys_clk,
  output logic      shift_clock_in,
  output logic      latch_clock_in,
  output logic      serial_in
);
  // Idle levels; both pin clocks stand still between frames
  initial
  begin
    shift_clock_in = 1'h0;
    latch_clock_in = 1'h0;
    serial_in      = 1'h0;
  end
  // Half period of the 800 ns link clock, moved just after an edge
  task automatic half;
    repeat (4) @(posedge sys_clk);
    #1;
  endtask : half
  // First bit sent ends in the last stage
  task automatic send(input logic [7:0] d);
    for (int i = 7; i >= 0; i--)
    begin
      serial_in = d[i];
      half();
      shift_clock_in = 1'h1;
      half();
      shift_clock_in = 1'h0;
    end
  endtask : send
  // One latch edge after the frame
  task automatic latch;
    latch_clock_in = 1'h1;
    half();
    latch_clock_in = 1'h0;
    half();
  endtask : latch
endmodule : ctl_model

// >>> verif/tb_serial_in_latched_low_side_driver.sv
// Testbench for the serial-in latched low-side driver
`timescale 1ns/10ps
module tb_serial_in_latched_low_side_driver;
  logic       sys_clk, rst_b, clk_en, shift_clear_n, out_enable_n, sck, lck, sdi, cas;
  logic [7:0] on, dro, droe;
  int         error_cnt, compares;
  ctl_model ctl_u (.sys_clk(sys_clk), .shift_clock_in(sck), .latch_clock_in(lck),
    .serial_in(sdi));
  serial_in_latched_low_side_driver dut_u (.sys_clk(sys_clk), .rst_b(rst_b), .clk_en(clk_en),
    .shift_clock_in(sck), .latch_clock_in(lck), .shift_clear_n(shift_clear_n),
    .out_enable_n(out_enable_n), .serial_in(sdi), .serial_cascade_out(cas),
    .switch_on(on), .switch_drain_o(dro), .switch_drain_oe_n(droe));
  // Clock of 100 ns
  initial
  begin
    sys_clk = 1'h0;
    forever #50 sys_clk = ~sys_clk;
  end
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    compares++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic conclude;
    if (error_cnt == 0 && compares > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : conclude
  // Shift a word, outputs wait for the latch edge
  task automatic shift_latch;
    ctl_u.send(8'ha5);
    chk({7'h00, cas}, 8'h01);
    chk(on, 8'h00);
    ctl_u.latch();
    chk(on, 8'ha5);
    chk(droe, 8'h5a);
    chk(dro, 8'h00);
  endtask : shift_latch
  // Frozen clock enable holds the switches; enable high turns them off, low restores
  task automatic enable_gate;
    clk_en       = 1'h0;
    out_enable_n = 1'h1;
    repeat (5) @(posedge sys_clk);
    #1;
    chk(on, 8'ha5);
    clk_en = 1'h1;
    repeat (5) @(posedge sys_clk);
    #1;
    chk(on, 8'h00);
    chk(droe, 8'hff);
    out_enable_n = 1'h0;
    repeat (5) @(posedge sys_clk);
    #1;
    chk(on, 8'ha5);
  endtask : enable_gate
  // Clear empties the shift stages but not the storage
  task automatic clear_shift;
    ctl_u.send(8'hff);
    shift_clear_n = 1'h0;
    repeat (5) @(posedge sys_clk);
    #1 shift_clear_n = 1'h1;
    chk({7'h00, cas}, 8'h00);
    chk(on, 8'ha5);
    ctl_u.latch();
    chk(on, 8'h00);
  endtask : clear_shift
  // Main sequence
  initial
  begin
    rst_b         = 1'h0;
    clk_en        = 1'h1;
    shift_clear_n = 1'h1;
    out_enable_n  = 1'h0;
    repeat (8) @(posedge sys_clk);
    #1 rst_b = 1'h1;
    chk(droe, 8'hff);
    shift_latch();
    enable_gate();
    clear_shift();
    conclude();
  end
endmodule : tb_serial_in_latched_low_side_driver
